// file: logic/pesd_select_decode.sv
// Event-selection decode feeding one performance counter.
// Operation
// - CAH/08H counts retired computational scalar-double vector ops, no loads, stores, logic.
// - CBH/01H counts retired loads missing first level, hitting second level cache.
// - CBH/02H counts retired loads missing the second level cache.
// - CBH/04H counts retired translation-buffer-miss loads, except loads that fault.
// - CDH/00H counts one per vector microcode assist invoked.
// - Multimedia-state-empty after packed-integer stack change is an assist.
// - Denormal input with flag clear, underflow with flush flag clear, are assists.
// - CEH/00H counts every retired vector instruction.
// - CFH/00H counts retired saturating vector instructions.
// - E0H/01H counts each decoded branch.
// - E4H/01H counts false taken branches; each raises front-end clear and buffer flush.
// - E6H/01H counts each front-end redirect for branch prediction.
`include "pesd_params.svh"
module pesd_select_decode
   import pesd_pkg::*;
(
   // Clock and reset.
   input wire logic mclk,
   input wire logic rst,
   // Counter programming.
   input wire pesd_code_t evt_num,
   input wire pesd_code_t umask,
   // Vector retirement occurrences.
   input wire logic vec_sd_retire,
   input wire logic vec_sd_not_arith,
   input wire logic vector_retire,
   input wire logic saturating_retire,
   // Load retirement occurrences.
   input wire logic load_retire,
   input wire logic load_l1_miss,
   input wire logic load_l2_hit,
   input wire logic load_l2_miss,
   input wire logic load_xlat_miss,
   input wire logic load_fault,
   // Assist causes.
   input wire logic multimedia_state_empty_instr,
   input wire logic packed_int_state_dirty,
   input wire logic denormal_input,
   input wire logic denormals_as_zero_flag,
   input wire logic underflow_result,
   input wire logic flush_to_zero_flag,
   // Front-end occurrences.
   input wire logic branch_decoded,
   input wire logic false_taken_branch,
   input wire logic front_end_redirect,
   // Counter and front-end outputs.
   output logic count_inc_ff,
   output logic precise_ff,
   output logic front_end_clear_ff,
   output logic branch_target_buffer_flush_ff
);
   // =====================================================================
   // Selection
   pesd_sel_t sel;

   pesd_event_match u_match (
      .evt_num(evt_num),
      .umask(umask),
      .sel(sel)
   );

   // =====================================================================
   // Occurrence qualification
   // Loads, stores and logical operations are flagged by the core and dropped.
   wire vector_arith_retire_count = vec_sd_retire & ~vec_sd_not_arith;
   wire l2_hit_load = load_retire & load_l1_miss & load_l2_hit;
   wire l2_miss_load = load_retire & load_l2_miss;
   // A faulting load never reaches retirement cleanly, so its miss is not counted.
   wire xlat_miss_load = load_retire & load_xlat_miss & ~load_fault;
   // A state-empty instruction only needs help when packed-integer code touched the stack.
   wire state_empty_assist = multimedia_state_empty_instr & packed_int_state_dirty;
   wire denorm_assist = denormal_input & ~denormals_as_zero_flag;
   wire uflow_assist = underflow_result & ~flush_to_zero_flag;
   // Several causes in one cycle belong to one assist, so they merge to one count.
   wire vector_microcode_help_count = state_empty_assist | denorm_assist | uflow_assist;

   // Pick the occurrence that the programmed selection names.
   logic nxt_count_inc;
   always_comb begin
      case (sel)
         PESD_SEL_VEC_ARITH: nxt_count_inc = vector_arith_retire_count;
         PESD_SEL_L2_HIT: nxt_count_inc = l2_hit_load;
         PESD_SEL_L2_MISS: nxt_count_inc = l2_miss_load;
         PESD_SEL_XLAT_MISS: nxt_count_inc = xlat_miss_load;
         PESD_SEL_ASSIST: nxt_count_inc = vector_microcode_help_count;
         PESD_SEL_VEC_RETIRE: nxt_count_inc = vector_retire;
         PESD_SEL_SAT_RETIRE: nxt_count_inc = saturating_retire;
         PESD_SEL_BR_DECODE: nxt_count_inc = branch_decoded;
         PESD_SEL_FALSE_BR: nxt_count_inc = false_taken_branch;
         PESD_SEL_REDIRECT: nxt_count_inc = front_end_redirect;
         default: nxt_count_inc = `PESD_RST_BIT;
      endcase
   end

   // Load-outcome events are the precise ones.
   wire nxt_precise = (sel == PESD_SEL_L2_HIT) | (sel == PESD_SEL_L2_MISS) |
                      (sel == PESD_SEL_XLAT_MISS);
   // A false taken branch always clears the front end, whatever is selected.
   wire nxt_fe_clear = false_taken_branch | front_end_redirect;

   // =====================================================================
   // Output registers
   // One cycle of latency keeps every output straight from a flip-flop.
   always_ff @(posedge mclk) begin
      if (rst) begin
         count_inc_ff <= `PESD_RST_BIT;
         precise_ff <= `PESD_RST_BIT;
         front_end_clear_ff <= `PESD_RST_BIT;
         branch_target_buffer_flush_ff <= `PESD_RST_BIT;
      end else begin
         count_inc_ff <= nxt_count_inc;
         precise_ff <= nxt_precise;
         front_end_clear_ff <= nxt_fe_clear;
         branch_target_buffer_flush_ff <= false_taken_branch;
      end
   end

   // =====================================================================
   // Assertions
   // Every check is disabled in reset; all but chk_known_decoded look one edge after their cause, which matches
   // the single register stage in front of the outputs.
   wire is_arith = (evt_num == `PESD_EV_VEC_ARITH) && (umask == `PESD_UM_SCALAR_DBL);
   wire is_load = evt_num == `PESD_EV_LOAD;
   wire is_assist = (evt_num == `PESD_EV_ASSIST) && (umask == `PESD_UM_NONE);

   // The valid pairs are rebuilt here from the constants, apart from the decoder,
   // so that a slip in the decoder shows up instead of being copied into the checks.
   wire is_vec_ret = (evt_num == `PESD_EV_VEC_RETIRE) && (umask == `PESD_UM_NONE);
   wire is_sat = (evt_num == `PESD_EV_SAT_RETIRE) && (umask == `PESD_UM_NONE);
   wire is_fe_pair = ((evt_num == `PESD_EV_BR_DECODE) || (evt_num == `PESD_EV_FALSE_BR) ||
                      (evt_num == `PESD_EV_REDIRECT)) && (umask == `PESD_UM_ONE);
   wire is_load_pair = is_load && ((umask == `PESD_UM_L2_HIT) || (umask == `PESD_UM_L2_MISS) ||
                       (umask == `PESD_UM_XLAT_MISS));
   wire is_known = is_arith || is_load_pair || is_assist || is_vec_ret || is_sat || is_fe_pair;
   wire is_false_br = (evt_num == `PESD_EV_FALSE_BR) && (umask == `PESD_UM_ONE);

   // Assist causes rebuilt from the pins rather than taken from the merged wire above.
   wire any_assist_cause = (multimedia_state_empty_instr && packed_int_state_dirty) ||
                           (denormal_input && !denormals_as_zero_flag) ||
                           (underflow_result && !flush_to_zero_flag);

   // Checks on the counted pairs and on the front-end outputs of a false branch.

   chk_arith_excl_logic: assert property (@(posedge mclk) disable iff (rst)
      is_arith && vec_sd_retire |=> count_inc_ff == !$past(vec_sd_not_arith))
      else $error("scalar-double count wrong");
   chk_l2_hit_load: assert property (@(posedge mclk) disable iff (rst)
      is_load && umask == `PESD_UM_L2_HIT && load_retire && load_l1_miss && load_l2_hit
      |=> count_inc_ff && precise_ff)
      else $error("second-level hit load not counted");
   chk_l2_miss_load: assert property (@(posedge mclk) disable iff (rst)
      is_load && umask == `PESD_UM_L2_MISS |=> count_inc_ff == $past(load_retire & load_l2_miss))
      else $error("second-level miss count wrong");
   chk_xlat_no_fault: assert property (@(posedge mclk) disable iff (rst)
      is_load && umask == `PESD_UM_XLAT_MISS && load_fault |=> !count_inc_ff)
      else $error("faulting load counted");
   chk_assist_once: assert property (@(posedge mclk) disable iff (rst)
      is_assist |=> count_inc_ff == $past(any_assist_cause))
      else $error("assist count wrong");
   chk_state_empty_assist: assert property (@(posedge mclk) disable iff (rst)
      is_assist && multimedia_state_empty_instr && packed_int_state_dirty |=> count_inc_ff)
      else $error("state-empty assist missed");
   chk_denorm_assist: assert property (@(posedge mclk) disable iff (rst)
      is_assist && ((denormal_input && !denormals_as_zero_flag) ||
      (underflow_result && !flush_to_zero_flag)) |=> count_inc_ff)
      else $error("denormal or underflow assist missed");
   chk_vec_retire: assert property (@(posedge mclk) disable iff (rst)
      evt_num == `PESD_EV_VEC_RETIRE && umask == `PESD_UM_NONE
      |=> count_inc_ff == $past(vector_retire))
      else $error("vector retire count wrong");
   chk_sat_retire: assert property (@(posedge mclk) disable iff (rst)
      evt_num == `PESD_EV_SAT_RETIRE && umask == `PESD_UM_NONE
      |=> count_inc_ff == $past(saturating_retire))
      else $error("saturating retire count wrong");
   chk_branch_decode: assert property (@(posedge mclk) disable iff (rst)
      evt_num == `PESD_EV_BR_DECODE && umask == `PESD_UM_ONE
      |=> count_inc_ff == $past(branch_decoded))
      else $error("decoded branch count wrong");
   chk_false_branch: assert property (@(posedge mclk) disable iff (rst)
      false_taken_branch |=> front_end_clear_ff && branch_target_buffer_flush_ff)
      else $error("false branch did not clear front end");
   chk_redirect_count: assert property (@(posedge mclk) disable iff (rst)
      evt_num == `PESD_EV_REDIRECT && umask == `PESD_UM_ONE
      |=> count_inc_ff == $past(front_end_redirect))
      else $error("redirect count wrong");
   chk_no_match_idle: assert property (@(posedge mclk) disable iff (rst)
      !is_known |=> !count_inc_ff)
      else $error("count without matching selection");

   // =====================================================================
   // Further checks on the decoder, the counts, the front-end outputs and the precise flag
   // The decoder must agree with the rebuilt pair list in the other direction too.
   chk_known_decoded: assert property (@(posedge mclk) disable iff (rst)
      is_known |-> sel != PESD_SEL_NONE)
      else $error("valid selection not decoded");

   // A false taken branch is counted under its own pair only.
   chk_false_br_count: assert property (@(posedge mclk) disable iff (rst)
      is_false_br |=> count_inc_ff == $past(false_taken_branch))
      else $error("false taken branch count wrong");

   // The flush belongs to false branches alone; a plain redirect keeps the buffer.
   chk_flush_only_false: assert property (@(posedge mclk) disable iff (rst)
      !false_taken_branch |=> !branch_target_buffer_flush_ff)
      else $error("buffer flushed without a false branch");

   // A redirect is itself a front-end clear, whether it is counted or not.
   chk_redirect_clear: assert property (@(posedge mclk) disable iff (rst)
      front_end_redirect |=> front_end_clear_ff)
      else $error("redirect did not clear front end");

   // Only the load-outcome pairs are precise events.
   chk_precise_load: assert property (@(posedge mclk) disable iff (rst)
      is_load_pair |=> precise_ff)
      else $error("load selection not marked precise");
   chk_precise_other: assert property (@(posedge mclk) disable iff (rst)
      !is_load_pair |=> !precise_ff)
      else $error("non-load selection marked precise");

   // A load without a first-level miss never counts as a second-level hit.
   chk_l2_hit_needs_miss: assert property (@(posedge mclk) disable iff (rst)
      is_load && umask == `PESD_UM_L2_HIT && !load_l1_miss |=> !count_inc_ff)
      else $error("load counted without first-level miss");

   // A clean retired translation miss must be counted.
   chk_xlat_counted: assert property (@(posedge mclk) disable iff (rst)
      is_load && umask == `PESD_UM_XLAT_MISS && load_retire && load_xlat_miss && !load_fault
      |=> count_inc_ff)
      else $error("translation-miss load not counted");
endmodule

// file: logic/pesd_params.svh
// Event and unit-mask encodings for the event-selection decode.
`ifndef PESD_PARAMS_SVH
`define PESD_PARAMS_SVH
// =====================================================================
// Event numbers.
`define PESD_EV_VEC_ARITH 8'hCA
`define PESD_EV_LOAD 8'hCB
`define PESD_EV_ASSIST 8'hCD
`define PESD_EV_VEC_RETIRE 8'hCE
`define PESD_EV_SAT_RETIRE 8'hCF
`define PESD_EV_BR_DECODE 8'hE0
`define PESD_EV_FALSE_BR 8'hE4
`define PESD_EV_REDIRECT 8'hE6
// =====================================================================
// Unit masks.
`define PESD_UM_NONE 8'h00
`define PESD_UM_SCALAR_DBL 8'h08
`define PESD_UM_L2_HIT 8'h01
`define PESD_UM_L2_MISS 8'h02
`define PESD_UM_XLAT_MISS 8'h04
`define PESD_UM_ONE 8'h01
// =====================================================================
// Reset values.
`define PESD_RST_BIT 1'b0
`endif

// file: logic/pesd_pkg.sv
// Types shared by the event-selection decode modules.
package pesd_pkg;
   typedef logic [7:0] pesd_code_t;
   typedef enum logic [3:0] {
      PESD_SEL_NONE,
      PESD_SEL_VEC_ARITH,
      PESD_SEL_L2_HIT,
      PESD_SEL_L2_MISS,
      PESD_SEL_XLAT_MISS,
      PESD_SEL_ASSIST,
      PESD_SEL_VEC_RETIRE,
      PESD_SEL_SAT_RETIRE,
      PESD_SEL_BR_DECODE,
      PESD_SEL_FALSE_BR,
      PESD_SEL_REDIRECT
   } pesd_sel_t;
endpackage

// file: logic/pesd_event_match.sv
// Matches the programmed event number and unit mask to one occurrence.
`include "pesd_params.svh"
module pesd_event_match
   import pesd_pkg::*;
(
   // Programmed selection.
   input wire pesd_code_t evt_num,
   input wire pesd_code_t umask,
   // Decoded occurrence.
   output pesd_sel_t sel
);
   // =====================================================================
   // Decode
   // Both fields must match exactly; any other pair selects nothing.
   function automatic logic pesd_hit(input pesd_code_t en, input pesd_code_t um,
                                     input pesd_code_t ref_en, input pesd_code_t ref_um);
      pesd_hit = (en == ref_en) && (um == ref_um);
   endfunction

   // One compare per documented encoding, priority-free since all are distinct.
   wire hit_arith = pesd_hit(evt_num, umask, `PESD_EV_VEC_ARITH, `PESD_UM_SCALAR_DBL);
   wire hit_l2h = pesd_hit(evt_num, umask, `PESD_EV_LOAD, `PESD_UM_L2_HIT);
   wire hit_l2m = pesd_hit(evt_num, umask, `PESD_EV_LOAD, `PESD_UM_L2_MISS);
   wire hit_xlat = pesd_hit(evt_num, umask, `PESD_EV_LOAD, `PESD_UM_XLAT_MISS);
   wire hit_assist = pesd_hit(evt_num, umask, `PESD_EV_ASSIST, `PESD_UM_NONE);
   wire hit_vret = pesd_hit(evt_num, umask, `PESD_EV_VEC_RETIRE, `PESD_UM_NONE);
   wire hit_sat = pesd_hit(evt_num, umask, `PESD_EV_SAT_RETIRE, `PESD_UM_NONE);
   wire hit_brd = pesd_hit(evt_num, umask, `PESD_EV_BR_DECODE, `PESD_UM_ONE);
   wire hit_fbr = pesd_hit(evt_num, umask, `PESD_EV_FALSE_BR, `PESD_UM_ONE);
   wire hit_redir = pesd_hit(evt_num, umask, `PESD_EV_REDIRECT, `PESD_UM_ONE);

   // Selection from the compare results.
   assign sel = hit_arith ? PESD_SEL_VEC_ARITH :
                hit_l2h ? PESD_SEL_L2_HIT :
                hit_l2m ? PESD_SEL_L2_MISS :
                hit_xlat ? PESD_SEL_XLAT_MISS :
                hit_assist ? PESD_SEL_ASSIST :
                hit_vret ? PESD_SEL_VEC_RETIRE :
                hit_sat ? PESD_SEL_SAT_RETIRE :
                hit_brd ? PESD_SEL_BR_DECODE :
                hit_fbr ? PESD_SEL_FALSE_BR :
                hit_redir ? PESD_SEL_REDIRECT : PESD_SEL_NONE;
endmodule

// file: tb/pesd_core_model.sv
// Core pipeline model that presents occurrence reports to the event-selection decode.
module pesd_core_model (
   // Requested occurrences, one bit per pipeline report.
   input wire logic [18:0] occ_req,
   // Vector retirement reports.
   output logic vec_sd_retire,
   output logic vec_sd_not_arith,
   output logic vector_retire,
   output logic saturating_retire,
   // Load retirement reports.
   output logic load_retire,
   output logic load_l1_miss,
   output logic load_l2_hit,
   output logic load_l2_miss,
   output logic load_xlat_miss,
   output logic load_fault,
   // Assist causes and mode flags.
   output logic multimedia_state_empty_instr,
   output logic packed_int_state_dirty,
   output logic denormal_input,
   output logic denormals_as_zero_flag,
   output logic underflow_result,
   output logic flush_to_zero_flag,
   // Front-end reports.
   output logic branch_decoded,
   output logic false_taken_branch,
   output logic front_end_redirect
);
   timeunit 1ns;
   timeprecision 1ps;
   // =====================================================================
   // Report mapping.
   // The pipeline may report any mix in any cycle, so every bit passes straight through.
   assign {front_end_redirect, false_taken_branch, branch_decoded, flush_to_zero_flag, underflow_result,
           denormals_as_zero_flag, denormal_input, packed_int_state_dirty, multimedia_state_empty_instr,
           load_fault, load_xlat_miss, load_l2_miss, load_l2_hit, load_l1_miss, load_retire,
           saturating_retire, vector_retire, vec_sd_not_arith, vec_sd_retire} = occ_req;
endmodule

// file: tb/pesd_select_decode_tb.sv
// Self-checking bench for the event-selection decode.
module pesd_select_decode_tb;
   timeunit 1ns;
   timeprecision 1ps;
   // =====================================================================
   // Signals.
   logic mclk;
   logic rst;
   pesd_pkg::pesd_code_t evt_num;
   pesd_pkg::pesd_code_t umask;
   logic [18:0] occ_req;
   logic vec_sd_retire, vec_sd_not_arith, vector_retire, saturating_retire, load_retire, load_l1_miss;
   logic load_l2_hit, load_l2_miss, load_xlat_miss, load_fault, multimedia_state_empty_instr;
   logic packed_int_state_dirty, denormal_input, denormals_as_zero_flag, underflow_result, flush_to_zero_flag;
   logic branch_decoded, false_taken_branch, front_end_redirect;
   logic count_inc_ff, precise_ff, front_end_clear_ff, branch_target_buffer_flush_ff;
   int n_mismatch = 0;
   int tests_run = 0;
   // =====================================================================
   // Instances.
   pesd_core_model u_pesd_core_model (.occ_req, .vec_sd_retire, .vec_sd_not_arith, .vector_retire,
      .saturating_retire, .load_retire, .load_l1_miss, .load_l2_hit, .load_l2_miss, .load_xlat_miss,
      .load_fault, .multimedia_state_empty_instr, .packed_int_state_dirty, .denormal_input,
      .denormals_as_zero_flag, .underflow_result, .flush_to_zero_flag, .branch_decoded,
      .false_taken_branch, .front_end_redirect);
   pesd_select_decode u_pesd_select_decode (.mclk, .rst, .evt_num, .umask, .vec_sd_retire, .vec_sd_not_arith,
      .vector_retire, .saturating_retire, .load_retire, .load_l1_miss, .load_l2_hit, .load_l2_miss,
      .load_xlat_miss, .load_fault, .multimedia_state_empty_instr, .packed_int_state_dirty, .denormal_input,
      .denormals_as_zero_flag, .underflow_result, .flush_to_zero_flag, .branch_decoded,
      .false_taken_branch, .front_end_redirect, .count_inc_ff, .precise_ff, .front_end_clear_ff,
      .branch_target_buffer_flush_ff);
   // The clock runs at 100 MHz.
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   // =====================================================================
   // Helpers.
   task automatic check(input string name, input logic seen, input logic exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %b seen %b", name, exp, seen);
      end
   endtask
   // Drives one cycle at a falling edge and judges the registered answer at the next falling edge.
   task automatic step(input logic [7:0] ev, input logic [7:0] um, input logic [18:0] occ, input logic exp);
      evt_num = ev;
      umask = um;
      occ_req = occ;
      @(posedge mclk);
      @(negedge mclk);
      check("count_inc_ff", count_inc_ff, exp);
      check("precise_ff", precise_ff, ev == 8'hCB && um inside {8'h01, 8'h02, 8'h04});
      check("front_end_clear_ff", front_end_clear_ff, occ[17] | occ[18]);
      check("branch_target_buffer_flush_ff", branch_target_buffer_flush_ff, occ[17]);
   endtask
   task automatic end_of_test();
      $display("mismatches %0d of %0d checks", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // =====================================================================
   // Scenarios, each back to back with no idle cycle between occurrences.
   task automatic t_vector();
      step(8'hCA, 8'h08, 19'h00001, 1'b1);
      step(8'hCA, 8'h08, 19'h00003, 1'b0);
      step(8'hCA, 8'h08, 19'h00004, 1'b0);
      step(8'hCE, 8'h00, 19'h00004, 1'b1);
      step(8'hCE, 8'h00, 19'h00001, 1'b0);
      step(8'hCF, 8'h00, 19'h00008, 1'b1);
      step(8'hCF, 8'h00, 19'h00004, 1'b0);
   endtask
   task automatic t_loads();
      step(8'hCB, 8'h01, 19'h00070, 1'b1);
      step(8'hCB, 8'h01, 19'h00060, 1'b0);
      step(8'hCB, 8'h01, 19'h00050, 1'b0);
      step(8'hCB, 8'h02, 19'h00090, 1'b1);
      step(8'hCB, 8'h02, 19'h00080, 1'b0);
      step(8'hCB, 8'h02, 19'h00070, 1'b0);
      step(8'hCB, 8'h04, 19'h00110, 1'b1);
      step(8'hCB, 8'h04, 19'h00310, 1'b0);
      step(8'hCB, 8'h04, 19'h00100, 1'b0);
   endtask
   // Several causes in one cycle must still give a single increment.
   task automatic t_assist();
      step(8'hCD, 8'h00, 19'h00C00, 1'b1);
      step(8'hCD, 8'h00, 19'h00400, 1'b0);
      step(8'hCD, 8'h00, 19'h01000, 1'b1);
      step(8'hCD, 8'h00, 19'h03000, 1'b0);
      step(8'hCD, 8'h00, 19'h04000, 1'b1);
      step(8'hCD, 8'h00, 19'h0C000, 1'b0);
      step(8'hCD, 8'h00, 19'h05C00, 1'b1);
      step(8'hCD, 8'h01, 19'h01000, 1'b0);
   endtask
   task automatic t_front_end();
      step(8'hE0, 8'h01, 19'h10000, 1'b1);
      step(8'hE4, 8'h01, 19'h20000, 1'b1);
      step(8'hE6, 8'h01, 19'h40000, 1'b1);
      step(8'hE4, 8'h01, 19'h40000, 1'b0);
      step(8'hE0, 8'h01, 19'h20000, 1'b0);
   endtask
   task automatic t_mismatch();
      step(8'hCA, 8'h00, 19'h00001, 1'b0);
      step(8'hCE, 8'h01, 19'h00004, 1'b0);
      step(8'hCF, 8'h08, 19'h00008, 1'b0);
      step(8'hE6, 8'h00, 19'h40000, 1'b0);
      step(8'hCE, 8'h00, 19'h00000, 1'b0);
   endtask
   // =====================================================================
   // Main sequence; occurrences are held high during reset to show they are ignored.
   initial begin
      rst = 1'b1;
      evt_num = 8'hCB;
      umask = 8'h04;
      occ_req = 19'h7FFFF;
      repeat (10) @(negedge mclk);
      check("count_inc_ff", count_inc_ff, 1'b0);
      check("front_end_clear_ff", front_end_clear_ff, 1'b0);
      rst = 1'b0;
      occ_req = 19'h00000;
      @(negedge mclk);
      // The load pair left selected through reset is marked precise from the first edge after release.
      check("precise_ff", precise_ff, 1'b1);
      t_vector();
      t_loads();
      t_assist();
      t_front_end();
      t_mismatch();
      end_of_test();
   end
   // A stuck run is cut short and reported as a failure.
   initial begin
      repeat (2000) @(posedge mclk);
      n_mismatch++;
      end_of_test();
   end
endmodule
